/* inc/tca_pkg.sv */
// Shared constants, register map and carrier types for the channel A block.
package tca_pkg;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int          CNT_W    = 10;
	localparam int          PRE_W    = 16;
	localparam int          ADDR_W   = 8;
	localparam int          CTRL_W   = 7;
	localparam logic [9:0]  PER_RST  = 10'h3ff;
	localparam logic [9:0]  CMPA_RST = 10'h000;
	localparam logic [15:0] PRE_RST  = 16'h0000;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMPA = 8'h04;
	localparam logic [7:0] REG_PER  = 8'h08;
	localparam logic [7:0] REG_PRE  = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_CAPT = 8'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Mode select and pin function codes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;

	localparam logic [1:0] FN_NONE  = 2'h0;
	localparam logic [1:0] FN_LOW   = 2'h1;
	localparam logic [1:0] FN_HIGH  = 2'h2;
	localparam logic [1:0] FN_TGL   = 2'h3;

	localparam logic [1:0] FN_INACT = 2'h0;
	localparam logic [1:0] FN_ACT   = 2'h1;
	localparam logic [1:0] FN_WAVE  = 2'h2;
	localparam logic [1:0] FN_PULSE = 2'h3;

	localparam logic [1:0] FN_RISE  = 2'h0;
	localparam logic [1:0] FN_FALL  = 2'h1;
	localparam logic [1:0] FN_BOTH  = 2'h2;
	localparam logic [1:0] FN_OFF   = 2'h3;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// Packed in the bit order of the control register, bit 6 first.
	typedef struct packed {
		logic       chan_a_polarity;
		logic       chan_a_level_select;
		logic [1:0] chan_a_pin_function;
		logic [1:0] chan_a_mode_select;
		logic       counter_on_off;
	} tca_cfg_t;

	typedef struct packed {
		logic [CNT_W-1:0] cmpa;
		logic [CNT_W-1:0] per;
		logic [PRE_W-1:0] pre;
	} tca_tim_t;

	typedef struct packed {
		logic             pin;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] capt;
	} tca_stat_t;

endpackage : tca_pkg

/* core/tca_regs.sv */
// AXI4-Lite register slave for the channel A block.
`timescale 1ns/1ns
module tca_regs (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite slave
	input  wire logic [tca_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [tca_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Block side
	output tca_pkg::tca_cfg_t              cfg,
	output tca_pkg::tca_tim_t              tim,
	input  tca_pkg::tca_stat_t             stat
);
	import tca_pkg::*;

	// ------------------------------------------------------------
	// Byte-lane merge
	// ------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	logic              aw_hold_q, w_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0]  cmpa_q, per_q;
	logic [PRE_W-1:0]  pre_q;
	logic              do_wr;

	assign awready = !aw_hold_q;
	assign wready  = !w_hold_q;
	assign arready = !rvalid;
	assign do_wr   = aw_hold_q && w_hold_q && !bvalid;
	assign cfg     = tca_cfg_t'(ctrl_q);
	assign tim     = '{cmpa: cmpa_q, per: per_q, pre: pre_q};

	// ------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (awvalid && awready) begin
			aw_hold_q <= 1'b1;
			awaddr_q  <= awaddr;
		end else if (do_wr) begin
			aw_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wvalid && wready) begin
			w_hold_q <= 1'b1;
			wdata_q  <= wdata;
			wstrb_q  <= wstrb;
		end else if (do_wr) begin
			w_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= '0;
			cmpa_q <= CMPA_RST;
			per_q  <= PER_RST;
			pre_q  <= PRE_RST;
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp  <= RESP_OKAY;
			case (awaddr_q)
				REG_CTRL: ctrl_q <= CTRL_W'(wmerge(32'(ctrl_q), wdata_q, wstrb_q));
				REG_CMPA: cmpa_q <= CNT_W'(wmerge(32'(cmpa_q), wdata_q, wstrb_q));
				REG_PER:  per_q  <= CNT_W'(wmerge(32'(per_q), wdata_q, wstrb_q));
				REG_PRE:  pre_q  <= PRE_W'(wmerge(32'(pre_q), wdata_q, wstrb_q));
				default:  bresp  <= RESP_SLVERR;
			endcase
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			case (araddr)
				REG_CTRL: rdata <= 32'(ctrl_q);
				REG_CMPA: rdata <= 32'(cmpa_q);
				REG_PER:  rdata <= 32'(per_q);
				REG_PRE:  rdata <= 32'(pre_q);
				REG_STAT: rdata <= 32'({stat.pin, stat.cnt});
				REG_CAPT: rdata <= 32'(stat.capt);
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule : tca_regs

/* core/tca_chan_a.sv */
// Channel A pin control of a 10-bit timer: compare, PWM, capture, timer.
// Summary of operation
// RULE_01: Compare mode match drives pin low (01), high (10) or toggles (11).
// RULE_02: Compare mode with function 00 leaves the pin unchanged on match.
// RULE_03: PWM mode function: 00 inactive, 01 active, 10 waveform, 11 pulse.
// RULE_04: Capture mode function: 00 rising, 01 falling, 10 both, 11 off.
// RULE_05: Timer mode ignores the function field and the level bit.
// RULE_06: A match selecting the level already present changes nothing.
// RULE_07: Counter switching on returns the compare pin to its initial level.
// RULE_08: Software should change the function field only while stopped.
// RULE_09: In compare mode the level bit gives the initial pin level.
// RULE_10: In PWM mode the level bit gives the active level.
// RULE_11: Mode field: 00 compare, 01 capture, 10 PWM, 11 timer.
// RULE_12: Counter switching on clears the counter; switching off holds it.
// RULE_13: Polarity bit inverts the pin output, except in capture and timer modes.
// RULE_14: Comparator A matches the full 10-bit counter to the compare value.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module tca_chan_a (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite slave
	input  wire logic [tca_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [tca_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Channel A pin
	input  wire logic                      chan_a_pin_i,
	output logic                           chan_a_pin_o,
	output logic                           chan_a_pin_oe_n
);
	import tca_pkg::*;

	tca_cfg_t         cfg;
	tca_tim_t         tim;
	tca_stat_t        stat;
	logic [PRE_W-1:0] div_q;
	logic [CNT_W-1:0] cnt_q, capt_q;
	logic             on_q, on_rise, tick, match;
	logic             lvl_q, sp_done_q, pin_q, oe_n_q;
	logic             raw, pin_d;
	logic             s1_q, s2_q, s3_q, edge_r, edge_f, cap_evt;

	tca_regs u_regs (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.cfg     (cfg),
		.tim     (tim),
		.stat    (stat)
	);

	assign stat = '{pin: pin_q, cnt: cnt_q, capt: capt_q};
	assign chan_a_pin_o    = pin_q;
	assign chan_a_pin_oe_n = oe_n_q;

	// Returns the pin level for an active or inactive PWM state.
	function automatic logic drive(input logic act, input logic lvl);
		return act ? lvl : !lvl;
	endfunction : drive

	// ------------------------------------------------------------
	// Counter clock divider and counter
	// ------------------------------------------------------------
	assign tick    = cfg.counter_on_off && (div_q >= tim.pre);
	assign on_rise = cfg.counter_on_off && !on_q;
	assign match   = tick && (cnt_q == tim.cmpa); // RULE_14

	always_ff @(posedge aclk) begin
		if (!aresetn || !cfg.counter_on_off || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_q <= 1'b0;
		end else begin
			on_q <= cfg.counter_on_off;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (on_rise) begin
			cnt_q <= '0; // RULE_12
		end else if (tick) begin
			cnt_q <= (cnt_q == tim.per) ? '0 : cnt_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Compare output level and single pulse state
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_q <= 1'b0;
		end else if (on_rise) begin
			lvl_q <= cfg.chan_a_level_select; // RULE_07 RULE_09
		end else if (match && cfg.chan_a_mode_select == MODE_CMP) begin
			case (cfg.chan_a_pin_function) // RULE_01 RULE_02 RULE_06
				FN_LOW:  lvl_q <= 1'b0;
				FN_HIGH: lvl_q <= 1'b1;
				FN_TGL:  lvl_q <= !lvl_q;
				default: lvl_q <= lvl_q;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || on_rise) begin
			sp_done_q <= 1'b0;
		end else if (match && cfg.chan_a_mode_select == MODE_PWM) begin
			sp_done_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Pin output
	// ------------------------------------------------------------
	always_comb begin
		raw = 1'b0;
		case (cfg.chan_a_mode_select) // RULE_11
			MODE_CMP: raw = lvl_q;
			MODE_PWM: begin
				case (cfg.chan_a_pin_function) // RULE_03 RULE_10
					FN_INACT: raw = drive(1'b0, cfg.chan_a_level_select);
					FN_ACT:   raw = drive(1'b1, cfg.chan_a_level_select);
					FN_WAVE:  raw = drive(cfg.counter_on_off
						&& (cnt_q < tim.cmpa), cfg.chan_a_level_select);
					default:  raw = drive(cfg.counter_on_off && !sp_done_q,
						cfg.chan_a_level_select);
				endcase
			end
			default: raw = 1'b0; // RULE_05
		endcase
	end

	// Capture and timer modes leave the pin undriven at a fixed low.
	assign pin_d = (cfg.chan_a_mode_select == MODE_CMP
		|| cfg.chan_a_mode_select == MODE_PWM)
		? raw ^ cfg.chan_a_polarity : 1'b0; // RULE_13

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			pin_q  <= pin_d;
			oe_n_q <= !(cfg.chan_a_mode_select == MODE_CMP
				|| cfg.chan_a_mode_select == MODE_PWM);
		end
	end

	// ------------------------------------------------------------
	// Capture input
	// ------------------------------------------------------------
	assign edge_r = s2_q && !s3_q;
	assign edge_f = !s2_q && s3_q;

	always_comb begin
		case (cfg.chan_a_pin_function) // RULE_04
			FN_RISE: cap_evt = edge_r;
			FN_FALL: cap_evt = edge_f;
			FN_BOTH: cap_evt = edge_r || edge_f;
			default: cap_evt = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= chan_a_pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capt_q <= '0;
		end else if (cfg.chan_a_mode_select == MODE_CAP && cap_evt) begin
			capt_q <= cnt_q;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Checks stay quiet until one edge has passed with reset released,
	// so that no attempt judges the state that reset itself left behind.
	logic live_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !live_q);

	logic cmp_m;
	assign cmp_m = match && !on_rise && cfg.chan_a_mode_select == MODE_CMP;

	AST_CMP_LOW: assert property ( // RULE_01
		cmp_m && cfg.chan_a_pin_function == FN_LOW |=> !lvl_q)
		else $error("Compare low did not clear the level.");
	AST_CMP_TGL: assert property ( // RULE_01
		cmp_m && cfg.chan_a_pin_function == FN_TGL |=> lvl_q != $past(lvl_q))
		else $error("Compare toggle did not invert the level.");
	AST_CMP_HOLD: assert property ( // RULE_02
		!on_rise && !(cmp_m && cfg.chan_a_pin_function != FN_NONE)
		|=> $stable(lvl_q))
		else $error("Compare level moved without a match.");
	AST_RESTART: assert property ( // RULE_07
		on_rise |=> lvl_q == $past(cfg.chan_a_level_select) && cnt_q == '0)
		else $error("Switch on did not restore level and counter.");
	AST_CNT_HOLD: assert property ( // RULE_12
		!cfg.counter_on_off ##1 !cfg.counter_on_off |-> $stable(cnt_q))
		else $error("Counter moved while switched off.");
	AST_CMP_PIN: assert property ( // RULE_13
		cfg.chan_a_mode_select == MODE_CMP
		|=> pin_q == ($past(lvl_q) ^ $past(cfg.chan_a_polarity)) && !oe_n_q)
		else $error("Compare pin does not follow level and polarity.");
	AST_PWM_INACT: assert property ( // RULE_03
		cfg.chan_a_mode_select == MODE_PWM
		&& cfg.chan_a_pin_function == FN_INACT
		|=> pin_q == !($past(cfg.chan_a_level_select)
		^ $past(cfg.chan_a_polarity)))
		else $error("Inactive PWM pin level wrong.");
	AST_TMR_OFF: assert property ( // RULE_05
		cfg.chan_a_mode_select == MODE_TMR |=> oe_n_q && !pin_q)
		else $error("Timer mode drives the pin.");
	AST_CAP_RISE: assert property ( // RULE_04
		cfg.chan_a_mode_select == MODE_CAP
		&& cfg.chan_a_pin_function == FN_RISE && edge_r
		|=> capt_q == $past(cnt_q))
		else $error("Rising edge capture missed.");
	AST_CAP_OFF: assert property ( // RULE_04
		cfg.chan_a_pin_function == FN_OFF |=> $stable(capt_q))
		else $error("Capture taken while disabled.");

	COV_TGL: cover property (cmp_m && cfg.chan_a_pin_function == FN_TGL);
	COV_PULSE: cover property (cfg.chan_a_mode_select == MODE_PWM
		&& cfg.chan_a_pin_function == FN_PULSE && $rose(sp_done_q));
	COV_CAP: cover property (cfg.chan_a_mode_select == MODE_CAP && cap_evt);
	COV_ON: cover property (on_rise);

endmodule : tca_chan_a

/* tb/tca_pin_model.sv */
// Far-side circuit on the channel A pin: a pull-up and one driver.
`timescale 1ns/1ns
module tca_pin_model (
	// Block side
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	// Far-side driver
	input  wire logic ext_en,
	input  wire logic ext_lvl,
	// Resolved wire
	output logic      pin
);
	// The pull-up sets the level when nobody drives the wire.
	always_comb begin
		if (!pin_oe_n)
			pin = pin_o;
		else if (ext_en)
			pin = ext_lvl;
		else
			pin = 1'h1;
	end
endmodule : tca_pin_model

/* tb/tca_chan_a_test.sv */
// Self-checking bench for the channel A pin control block.
`timescale 1ns/1ns
module tca_chan_a_test;
	import tca_pkg::*;
	typedef struct packed {
		logic [1:0] md;
		logic [1:0] fn;
		logic [4:0] f;
	} tca_row_t;
	// ----
	// Signals
	// ----
	logic        aclk, aresetn, ok;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v, v2, c, p, pc;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic        pin, pin_o, pin_oe_n, ext_en, ext_lvl;
	int          error_cnt, n_tests, t0;
	int          cyc = 0;
	tca_row_t    r;
	logic [7:0]  ra[4] = '{REG_CTRL, REG_CMPA, REG_PER, REG_PRE};
	logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h3ff, 32'h0};
	// Flags: level bit, polarity, pin after on, pin after match, oe_n.
	tca_row_t    rows[17] = '{
		'{MODE_CMP, FN_NONE, 5'h00},
		'{MODE_CMP, FN_NONE, 5'h16},
		'{MODE_CMP, FN_LOW, 5'h14},
		'{MODE_CMP, FN_HIGH, 5'h02},
		'{MODE_CMP, FN_TGL, 5'h02},
		'{MODE_CMP, FN_TGL, 5'h14},
		'{MODE_CMP, FN_LOW, 5'h00},
		'{MODE_CMP, FN_HIGH, 5'h16},
		'{MODE_CMP, FN_LOW, 5'h1a},
		'{MODE_PWM, FN_INACT, 5'h10},
		'{MODE_PWM, FN_INACT, 5'h06},
		'{MODE_PWM, FN_ACT, 5'h16},
		'{MODE_PWM, FN_WAVE, 5'h14},
		'{MODE_PWM, FN_WAVE, 5'h0c},
		'{MODE_PWM, FN_PULSE, 5'h02},
		'{MODE_TMR, FN_WAVE, 5'h19},
		'{MODE_TMR, FN_PULSE, 5'h01}
	};

	tca_chan_a dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .chan_a_pin_i(pin), .chan_a_pin_o(pin_o),
		.chan_a_pin_oe_n(pin_oe_n)
	);
	tca_pin_model far (
		.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
		.ext_lvl(ext_lvl), .pin(pin)
	);

	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	// ----
	// Tasks
	// ----
	task automatic end_sim;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n > 100) begin
			error_cnt++;
			end_sim();
		end
	endtask : tmo

	task automatic wait_to(input int t);
		while (cyc < t)
			@(posedge aclk);
	endtask : wait_to

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int   n = 0;
		logic b = 1'h0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		while (!b) begin
			@(posedge aclk);
			n++;
			tmo(n);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid && bready) begin
				rsp = bresp;
				bready <= 1'h0;
				b = 1'h1;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int   n = 0;
		logic b = 1'h0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		while (!b) begin
			@(posedge aclk);
			n++;
			tmo(n);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid && rready) begin
				v = rdata;
				rsp = rresp;
				rready <= 1'h0;
				b = 1'h1;
			end
		end
	endtask : axi_rd

	// ----
	// Main sequence
	// ----
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{ext_en, ext_lvl} = 2'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		error_cnt = 0;
		n_tests = 0;
		p = 32'h0;
		pc = 32'h0;
		repeat (9) @(posedge aclk);
		chk("rst_oe_n", pin_oe_n, 1'h1);
		chk("rst_bvalid", bvalid, 1'h0);
		@(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		chk("rst_pin", {pin_oe_n, pin_o}, 2'h0);
		foreach (ra[i]) begin
			axi_rd(ra[i]);
			chk("reg_rst", v, rv[i]);
			chk("rd_resp", rsp, RESP_OKAY);
		end
		axi_rd(8'h18);
		chk("unmapped", v, 32'h0);
		chk("unmapped_resp", rsp, RESP_SLVERR);
		axi_wr(REG_STAT, 32'h5, 4'hf);
		chk("ro_write", rsp, RESP_SLVERR);
		axi_wr(REG_PRE, 32'h1234, 4'h1);
		chk("wr_resp", rsp, RESP_OKAY);
		axi_rd(REG_PRE);
		chk("strobe", v, 32'h34);
		axi_wr(REG_PRE, 32'h0, 4'hf);
		axi_wr(REG_CMPA, 32'h8, 4'hf);
		foreach (rows[i]) begin
			r = rows[i];
			c = {25'h0, r.f[3], r.f[4], r.fn, r.md, 1'h0};
			axi_wr(REG_CTRL, p, 4'hf);
			axi_wr(REG_CTRL, c, 4'hf);
			axi_wr(REG_CTRL, c | 32'h1, 4'hf);
			p = c;
			t0 = cyc;
			wait_to(t0 + 3);
			chk("pin_init", pin_o, r.f[2]);
			wait_to(t0 + 30);
			chk("pin_after", pin_o, r.f[1]);
			chk("oe_n", pin_oe_n, r.f[0]);
			chk("wire", pin, pin_oe_n | r.f[1]);
		end
		ext_en <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			c = {25'h0, 2'h0, k[1:0], MODE_CAP, 1'h0};
			axi_wr(REG_CTRL, p, 4'hf);
			axi_wr(REG_CTRL, c, 4'hf);
			axi_wr(REG_CTRL, c | 32'h1, 4'hf);
			p = c;
			t0 = cyc;
			wait_to(t0 + 20);
			ext_lvl <= 1'h1;
			wait_to(t0 + 40);
			axi_rd(REG_CAPT);
			ok = (k == 0 || k == 2) ? (v > 17 && v < 33) : (v === pc);
			chk("capt_rise", ok, 1'h1);
			pc = v;
			wait_to(t0 + 60);
			ext_lvl <= 1'h0;
			wait_to(t0 + 80);
			axi_rd(REG_CAPT);
			ok = (k == 1 || k == 2) ? (v > 57 && v < 73) : (v === pc);
			chk("capt_fall", ok, 1'h1);
			pc = v;
			chk("cap_oe_n", pin_oe_n, 1'h1);
		end
		axi_wr(REG_CTRL, p, 4'hf);
		axi_wr(REG_CTRL, 32'h10, 4'hf);
		axi_rd(REG_STAT);
		v2 = v;
		repeat (20) @(posedge aclk);
		axi_rd(REG_STAT);
		chk("cnt_hold", v[9:0], v2[9:0]);
		axi_wr(REG_CMPA, 32'h108, 4'hf);
		axi_wr(REG_CTRL, 32'h11, 4'hf);
		t0 = cyc;
		axi_rd(REG_STAT);
		chk("cnt_clear", v[9:0] < 10'h8, 1'h1);
		wait_to(t0 + 30);
		chk("low_bits", pin_o, 1'h0);
		wait_to(t0 + 280);
		chk("full_match", pin_o, 1'h1);
		axi_rd(REG_STAT);
		chk("stat_pin", v[10], 1'h1);
		axi_wr(REG_PER, 32'h10, 4'hf);
		axi_wr(REG_CTRL, 32'h10, 4'hf);
		axi_wr(REG_CTRL, 32'h11, 4'hf);
		repeat (40) @(posedge aclk);
		axi_rd(REG_STAT);
		chk("per_wrap", v[9:0] <= 10'h10, 1'h1);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk("mid_rst_pin", {pin_oe_n, pin_o}, 2'h2);
		axi_rd(REG_CTRL);
		chk("mid_rst_ctrl", v, 32'h0);
		axi_rd(REG_PER);
		chk("mid_rst_per", v, 32'h3ff);
		end_sim();
	end
endmodule : tca_chan_a_test
